// file: hw/timer8_compare_irq_regs.sv
// Purpose: 8-bit timer counter, two compare channels, mask and flag registers
// Assumes: apb slave, timer ticks on every clk_in while running
// Notes: vector acknowledges arrive as one-cycle pulses from the cpu core
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - counter value readable and writable directly by software.
// - counter write blocks compare matches on the next timer tick.
// - compare a checked against counter each tick; irq or pin.
// - compare b register resets to zero, matched each tick.
// - mask and flag bits 7..3 read zero.
// - mask bit 2 enables compare b interrupt with global enable.
// - mask bit 1 enables compare a interrupt with global enable.
// - mask bit 0 enables overflow interrupt with global enable.
// - compare b match sets flag bit 2.
// - compare a match sets flag bit 1.
// - overflow sets flag bit 0; point depends on waveform mode.
// - executing a flag's vector clears that flag.
// - writing one clears a flag; zero leaves it.
// - interrupt only when global, mask and flag all one.
// - overflow at ff, at 00 phase-correct, at top variable fast.
// - force strobe sets no flag, no ctc clear; reads zero.
module timer8_compare_irq_regs (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // cpu core side
   input wire logic global_irq_en_in,
   input wire logic [2:0] vector_ack_in,
   // interrupt requests
   output logic irq_ovf_out,
   output logic irq_cmp_a_out,
   output logic irq_cmp_b_out,
   // waveform pins
   output logic compare_a_pin_out,
   output logic compare_b_pin_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] counter_value_reg;
   logic [7:0] compare_a_value_reg;
   logic [7:0] compare_b_value_reg;
   logic [2:0] interrupt_mask_reg;
   logic [2:0] interrupt_flags_reg;
   logic [2:0] waveform_mode_sel_reg;
   logic run_reg;
   logic down_reg;
   logic block_reg;
   logic [7:0] counter_next;
   logic down_next;
   logic [7:0] top_value;
   logic is_pwm;
   logic is_pc;
   logic match_a;
   logic match_b;
   logic ovf_hit;
   logic [2:0] flags_next;
   timer8_pkg::irq_view_t view;

   logic apb_acc;
   logic apb_wr;
   logic wr_counter;
   logic wr_ctrl;
   logic addr_ok;
   logic force_a;
   logic force_b;

   assign apb_acc = psel_in & penable_in;
   assign apb_wr = apb_acc & pwrite_in;
   assign wr_counter = apb_wr && (paddr_in == timer8_pkg::OFF_COUNTER);
   assign wr_ctrl = apb_wr && (paddr_in == timer8_pkg::OFF_CTRL);
   // forced compare only meaningful in the non-pwm modes
   assign force_a = wr_ctrl & pwdata_in[timer8_pkg::CTRL_FOCA_BIT] & ~is_pwm;
   assign force_b = wr_ctrl & pwdata_in[timer8_pkg::CTRL_FOCB_BIT] & ~is_pwm;

   always_comb begin
      addr_ok = 1'b1;
      case (paddr_in)
         timer8_pkg::OFF_COUNTER, timer8_pkg::OFF_CMP_A, timer8_pkg::OFF_CMP_B,
         timer8_pkg::OFF_MASK, timer8_pkg::OFF_FLAGS, timer8_pkg::OFF_CTRL: begin
            addr_ok = 1'b1;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   always_comb begin
      is_pwm = 1'b0;
      is_pc = 1'b0;
      top_value = timer8_pkg::COUNT_MAX;
      case (waveform_mode_sel_reg)
         timer8_pkg::MODE_PC_FF: begin
            is_pwm = 1'b1;
            is_pc = 1'b1;
         end
         timer8_pkg::MODE_CTC: begin
            top_value = compare_a_value_reg;
         end
         timer8_pkg::MODE_FAST_FF: begin
            is_pwm = 1'b1;
         end
         timer8_pkg::MODE_PC_A: begin
            is_pwm = 1'b1;
            is_pc = 1'b1;
            top_value = compare_a_value_reg;
         end
         timer8_pkg::MODE_FAST_A: begin
            is_pwm = 1'b1;
            top_value = compare_a_value_reg;
         end
         default: begin
            top_value = timer8_pkg::COUNT_MAX;
         end
      endcase
   end

   // compares and overflow point
   always_comb begin
      match_a = run_reg && !block_reg && (counter_value_reg == compare_a_value_reg);
      match_b = run_reg && !block_reg && (counter_value_reg == compare_b_value_reg);
      if (is_pc) begin
         ovf_hit = run_reg && (counter_value_reg == timer8_pkg::COUNT_BOTTOM) && down_reg;
      end else if (waveform_mode_sel_reg == timer8_pkg::MODE_FAST_A) begin
         ovf_hit = run_reg && (counter_value_reg == top_value);
      end else begin
         ovf_hit = run_reg && (counter_value_reg == timer8_pkg::COUNT_MAX);
      end
   end

   // next count
   always_comb begin
      counter_next = counter_value_reg;
      down_next = down_reg;
      if (run_reg) begin
         if (is_pc) begin
            if (!down_reg && counter_value_reg >= top_value) begin
               down_next = 1'b1;
               counter_next = counter_value_reg - 8'h01;
            end else if (down_reg && counter_value_reg == timer8_pkg::COUNT_BOTTOM) begin
               down_next = 1'b0;
               counter_next = counter_value_reg + 8'h01;
            end else if (down_reg) begin
               counter_next = counter_value_reg - 8'h01;
            end else begin
               counter_next = counter_value_reg + 8'h01;
            end
         end else if (waveform_mode_sel_reg != timer8_pkg::MODE_NORMAL
                      && counter_value_reg == top_value) begin
            counter_next = timer8_pkg::COUNT_BOTTOM;
            down_next = 1'b0;
         end else begin
            counter_next = counter_value_reg + 8'h01;
            down_next = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter; a cpu write overrides counting
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         counter_value_reg <= timer8_pkg::RST_COUNTER;
         down_reg <= 1'b0;
      end else if (wr_counter) begin
         counter_value_reg <= pwdata_in[7:0];
         down_reg <= down_reg;
      end else begin
         counter_value_reg <= counter_next;
         down_reg <= down_next;
      end
   end

   // match blocker after counter write
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         block_reg <= 1'b0;
      end else if (wr_counter) begin
         block_reg <= 1'b1;
      end else if (run_reg) begin
         block_reg <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         compare_a_value_reg <= timer8_pkg::RST_CMP_A;
         compare_b_value_reg <= timer8_pkg::RST_CMP_B;
         interrupt_mask_reg <= timer8_pkg::RST_MASK;
         waveform_mode_sel_reg <= timer8_pkg::RST_MODE;
         run_reg <= 1'b0;
      end else if (apb_wr) begin
         case (paddr_in)
            timer8_pkg::OFF_CMP_A: begin
               compare_a_value_reg <= pwdata_in[7:0];
            end
            timer8_pkg::OFF_CMP_B: begin
               compare_b_value_reg <= pwdata_in[7:0];
            end
            timer8_pkg::OFF_MASK: begin
               interrupt_mask_reg <= pwdata_in[2:0];
            end
            timer8_pkg::OFF_CTRL: begin
               waveform_mode_sel_reg <= pwdata_in[timer8_pkg::CTRL_MODE_LSB +: 3];
               run_reg <= pwdata_in[timer8_pkg::CTRL_RUN_BIT];
            end
            default: begin
               run_reg <= run_reg;
            end
         endcase
      end
   end

   // flags: hardware set beats vector and write-one clears
   always_comb begin
      flags_next = interrupt_flags_reg & ~vector_ack_in;
      if (apb_wr && paddr_in == timer8_pkg::OFF_FLAGS) begin
         flags_next = flags_next & ~pwdata_in[2:0];
      end
      if (match_b) begin
         flags_next[timer8_pkg::BIT_CMPB] = 1'b1;
      end
      if (match_a) begin
         flags_next[timer8_pkg::BIT_CMPA] = 1'b1;
      end
      if (ovf_hit) begin
         flags_next[timer8_pkg::BIT_OVF] = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         interrupt_flags_reg <= timer8_pkg::RST_FLAGS;
      end else begin
         interrupt_flags_reg <= flags_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // waveform pins: toggle on match, forced strobe toggles too
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         compare_a_pin_out <= 1'b0;
         compare_b_pin_out <= 1'b0;
      end else begin
         if (match_a || force_a) begin
            compare_a_pin_out <= ~compare_a_pin_out;
         end
         if (match_b || force_b) begin
            compare_b_pin_out <= ~compare_b_pin_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb: zero wait states, error on unmapped address
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~addr_ok;
         prdata_out <= 32'h0000_0000;
         if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
               timer8_pkg::OFF_COUNTER: begin
                  prdata_out <= {24'h000000, counter_value_reg};
               end
               timer8_pkg::OFF_CMP_A: begin
                  prdata_out <= {24'h000000, compare_a_value_reg};
               end
               timer8_pkg::OFF_CMP_B: begin
                  prdata_out <= {24'h000000, compare_b_value_reg};
               end
               timer8_pkg::OFF_MASK: begin
                  prdata_out <= {29'h0000_0000, interrupt_mask_reg};
               end
               timer8_pkg::OFF_FLAGS: begin
                  prdata_out <= {29'h0000_0000, interrupt_flags_reg};
               end
               timer8_pkg::OFF_CTRL: begin
                  prdata_out <= {28'h000_0000, run_reg, waveform_mode_sel_reg};
               end
               default: begin
                  prdata_out <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one request line per source
   assign view = '{mask: interrupt_mask_reg, flags: interrupt_flags_reg,
                   global_en: global_irq_en_in};

   timer8_irq_line u_irq_ovf (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flag_in(view.flags[timer8_pkg::BIT_OVF]),
      .enable_in(view.mask[timer8_pkg::BIT_OVF]),
      .global_in(view.global_en),
      .req_out(irq_ovf_out)
   );
   timer8_irq_line u_irq_a (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flag_in(view.flags[timer8_pkg::BIT_CMPA]),
      .enable_in(view.mask[timer8_pkg::BIT_CMPA]),
      .global_in(view.global_en),
      .req_out(irq_cmp_a_out)
   );
   timer8_irq_line u_irq_b (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flag_in(view.flags[timer8_pkg::BIT_CMPB]),
      .enable_in(view.mask[timer8_pkg::BIT_CMPB]),
      .global_in(view.global_en),
      .req_out(irq_cmp_b_out)
   );

   ////////////////////////////////////////////////////////////////////////
   a_wr_blocks_match: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_counter |=> !match_a && !match_b) else $error("match right after counter write");
   a_cmp_a_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      match_a |=> interrupt_flags_reg[1]) else $error("compare a flag not set");
   a_cmp_b_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      match_b |=> interrupt_flags_reg[2]) else $error("compare b flag not set");
   a_ovf_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (run_reg && !is_pc && waveform_mode_sel_reg != 3'h7 && counter_value_reg == 8'hff)
      |=> interrupt_flags_reg[0]) else $error("overflow flag not set at ff");
   a_w1c_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (apb_wr && paddr_in == 8'h10 && pwdata_in[1] && !match_a)
      |=> !interrupt_flags_reg[1]) else $error("write one did not clear");
   a_w0_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (interrupt_flags_reg[2] && !vector_ack_in[2] && !(apb_wr && paddr_in == 8'h10
      && pwdata_in[2])) |=> interrupt_flags_reg[2]) else $error("flag lost");
   a_vector_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (vector_ack_in[0] && !ovf_hit) |=> !interrupt_flags_reg[0])
      else $error("vector did not clear overflow");
   a_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      irq_cmp_a_out |-> $past(interrupt_flags_reg[1] && interrupt_mask_reg[1]
      && global_irq_en_in)) else $error("request without all three enables");
   a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ($past(psel_in && !penable_in && !pwrite_in && (paddr_in == 8'h0c || paddr_in == 8'h10)))
      |-> prdata_out[7:3] == 5'h00) else $error("reserved bits read nonzero");
   a_force_no_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (force_a && !match_a && !interrupt_flags_reg[1] && !ovf_hit)
      |=> !interrupt_flags_reg[1]) else $error("force set a flag");
endmodule
`default_nettype wire

// file: hw/timer8_pkg.sv
// Purpose: shared constants and types for the 8-bit timer block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package timer8_pkg;
   localparam logic [7:0] OFF_COUNTER = 8'h00;
   localparam logic [7:0] OFF_CMP_A = 8'h04;
   localparam logic [7:0] OFF_CMP_B = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_FLAGS = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h14;
   localparam logic [7:0] RST_COUNTER = 8'h00;
   localparam logic [7:0] RST_CMP_A = 8'h00;
   localparam logic [7:0] RST_CMP_B = 8'h00;
   localparam logic [2:0] RST_MASK = 3'h0;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam int BIT_OVF = 0;
   localparam int BIT_CMPA = 1;
   localparam int BIT_CMPB = 2;
   // control word: mode in [2:0], run in [3], force strobes in [7:6]
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RUN_BIT = 3;
   localparam int CTRL_FOCB_BIT = 6;
   localparam int CTRL_FOCA_BIT = 7;
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_FF = 3'h1;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FAST_FF = 3'h3;
   localparam logic [2:0] MODE_PC_A = 3'h5;
   localparam logic [2:0] MODE_FAST_A = 3'h7;
   typedef struct packed {
      logic [2:0] mask;
      logic [2:0] flags;
      logic global_en;
   } irq_view_t;
endpackage

// file: hw/timer8_irq_line.sv
// Purpose: one interrupt request line from flag, mask and global enable
// Assumes: all inputs on clk_in
// Notes: output registered
`timescale 1ns/1ps
`default_nettype none
module timer8_irq_line (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // source
   input wire logic flag_in,
   input wire logic enable_in,
   input wire logic global_in,
   // request
   output logic req_out
);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         req_out <= 1'b0;
      end else begin
         req_out <= flag_in & enable_in & global_in;
      end
   end
endmodule
`default_nettype wire

// file: dv/cpu_core_model.sv
// Purpose: cpu core stand-in that takes the timer's interrupt requests
// Assumes: one vector served at a time, the handler blocks the others
// Notes: slow_in adds three cycles before each vector is taken
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // bench control
   input wire logic global_set_in,
   input wire logic accept_in,
   input wire logic slow_in,
   // interrupt requests, {cmp b, cmp a, ovf}
   input wire logic [2:0] irq_in,
   // status bit and vector acknowledge
   output logic global_irq_en_out,
   output logic [2:0] vector_ack_out
);
   logic [2:0] wait_reg;
   logic [2:0] hold_reg;
   // i-bit cleared while a handler runs, as on a real core
   assign global_irq_en_out = global_set_in && (hold_reg == 3'h0);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         vector_ack_out <= 3'h0;
         wait_reg <= 3'h0;
         hold_reg <= 3'h0;
      end else begin
         vector_ack_out <= 3'h0;
         if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
         end else if (accept_in && global_irq_en_out && (irq_in != 3'h0)) begin
            if (slow_in && (wait_reg != 3'h3)) begin
               wait_reg <= wait_reg + 3'h1;
            end else begin
               // lowest source first; hold outlasts the late request drop
               vector_ack_out <= irq_in & (~irq_in + 3'h1);
               wait_reg <= 3'h0;
               hold_reg <= 3'h4;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench for the 8-bit timer register block
// Assumes: zero-wait apb slave, timer ticks every clock while running
// Notes: counter is stopped around every register check
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic gset, accept, slow, gen, irq_o, irq_a, irq_b, pin_a, pin_b;
   logic [2:0] ack;
   int err_count = 0;
   int num_checks = 0;
   localparam logic [31:0] RUN = 32'h1 << timer8_pkg::CTRL_RUN_BIT;
   localparam logic [31:0] FORCE = (32'h1 << timer8_pkg::CTRL_FOCA_BIT)
      | (32'h1 << timer8_pkg::CTRL_FOCB_BIT);

   timer8_compare_irq_regs i_timer8_compare_irq_regs (.clk_in(clk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .global_irq_en_in(gen), .vector_ack_in(ack), .irq_ovf_out(irq_o),
      .irq_cmp_a_out(irq_a), .irq_cmp_b_out(irq_b), .compare_a_pin_out(pin_a),
      .compare_b_pin_out(pin_b));
   cpu_core_model i_cpu_core_model (.clk_in(clk), .rst_n_in(rst_n), .global_set_in(gset),
      .accept_in(accept), .slow_in(slow), .irq_in({irq_b, irq_a, irq_o}),
      .global_irq_en_out(gen), .vector_ack_out(ack));

   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         n++;
         @(posedge clk);
      end
      `CHK("pready", 1'b1, pready)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      logic [31:0] rd;
      logic e;
      apb(1'b0, a, 32'h0, rd, e);
      `CHK(nm, ex, rd)
   endtask
   task automatic irqchk(input logic [2:0] ex);
      repeat (3) @(posedge clk);
      `CHK("irq_lines", ex, {irq_b, irq_a, irq_o})
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] rd;
      logic e;
      rdchk(timer8_pkg::OFF_COUNTER, 32'h0, "counter");
      rdchk(timer8_pkg::OFF_CMP_B, 32'h0, "cmp_b_reset");
      rdchk(timer8_pkg::OFF_MASK, 32'h0, "mask_reset");
      rdchk(timer8_pkg::OFF_FLAGS, 32'h0, "flags_reset");
      apb(1'b0, 8'h40, 32'h0, rd, e);
      `CHK("unmapped_err", 1'b1, e)
   endtask
   task automatic t_regs();
      wr(timer8_pkg::OFF_COUNTER, 32'h5a);
      rdchk(timer8_pkg::OFF_COUNTER, 32'h5a, "counter_rw");
      wr(timer8_pkg::OFF_CMP_A, 32'ha5);
      rdchk(timer8_pkg::OFF_CMP_A, 32'ha5, "cmp_a_rw");
      wr(timer8_pkg::OFF_CMP_B, 32'h3c);
      rdchk(timer8_pkg::OFF_CMP_B, 32'h3c, "cmp_b_rw");
      wr(timer8_pkg::OFF_MASK, 32'hff);
      rdchk(timer8_pkg::OFF_MASK, 32'h07, "mask_upper");
      wr(timer8_pkg::OFF_MASK, 32'h00);
      wr(timer8_pkg::OFF_CTRL, FORCE);
      rdchk(timer8_pkg::OFF_CTRL, 32'h0, "force_read");
      rdchk(timer8_pkg::OFF_FLAGS, 32'h0, "force_flags");
      `CHK("force_pins", 2'b11, {pin_b, pin_a})
   endtask
   // overflow and both matches in one short normal-mode run
   task automatic make_flags();
      logic [1:0] pins_before;
      pins_before = {pin_b, pin_a};
      wr(timer8_pkg::OFF_CMP_A, 32'hfe);
      wr(timer8_pkg::OFF_CMP_B, 32'h01);
      wr(timer8_pkg::OFF_COUNTER, 32'hfd);
      wr(timer8_pkg::OFF_CTRL, RUN);
      repeat (6) @(posedge clk);
      wr(timer8_pkg::OFF_CTRL, 32'h0);
      rdchk(timer8_pkg::OFF_FLAGS, 32'h07, "flags_all");
      // one match per channel in this run, so each pin toggles once
      `CHK("match_pins", ~pins_before, {pin_b, pin_a})
   endtask
   task automatic t_w1c();
      make_flags();
      wr(timer8_pkg::OFF_FLAGS, 32'h02);
      rdchk(timer8_pkg::OFF_FLAGS, 32'h05, "w1c_one");
      wr(timer8_pkg::OFF_FLAGS, 32'h00);
      rdchk(timer8_pkg::OFF_FLAGS, 32'h05, "w1c_zero");
      wr(timer8_pkg::OFF_FLAGS, 32'h05);
      rdchk(timer8_pkg::OFF_FLAGS, 32'h00, "w1c_rest");
   endtask
   task automatic t_irq();
      int n;
      int nack;
      n = 0;
      nack = 0;
      make_flags();
      gset <= 1'b1;
      irqchk(3'b000);
      wr(timer8_pkg::OFF_MASK, 32'h07);
      gset <= 1'b0;
      irqchk(3'b000);
      gset <= 1'b1;
      irqchk(3'b111);
      wr(timer8_pkg::OFF_MASK, 32'h03);
      irqchk(3'b011);
      wr(timer8_pkg::OFF_MASK, 32'h05);
      irqchk(3'b101);
      wr(timer8_pkg::OFF_MASK, 32'h06);
      irqchk(3'b110);
      wr(timer8_pkg::OFF_MASK, 32'h07);
      slow <= 1'b1;
      accept <= 1'b1;
      // lines drop while a handler holds the global enable low, so count vectors
      while (nack < 3 && n < 100) begin
         n++;
         @(posedge clk);
         if (ack != 3'h0) begin
            nack++;
         end
      end
      accept <= 1'b0;
      `CHK("vector_count", 3, nack)
      rdchk(timer8_pkg::OFF_FLAGS, 32'h0, "vector_clear");
      wr(timer8_pkg::OFF_MASK, 32'h00);
   endtask
   task automatic t_modes();
      logic [2:0] md [5] = '{timer8_pkg::MODE_NORMAL, timer8_pkg::MODE_CTC,
         timer8_pkg::MODE_FAST_FF, timer8_pkg::MODE_FAST_A, timer8_pkg::MODE_PC_A};
      // phase-correct with top 05: match on the way up, overflow back at bottom
      logic [31:0] ex [5] = '{32'h02, 32'h02, 32'h02, 32'h03, 32'h03};
      for (int i = 0; i < 5; i++) begin
         wr(timer8_pkg::OFF_FLAGS, 32'h07);
         wr(timer8_pkg::OFF_CMP_A, 32'h05);
         wr(timer8_pkg::OFF_CMP_B, 32'h80);
         wr(timer8_pkg::OFF_COUNTER, 32'h00);
         wr(timer8_pkg::OFF_CTRL, RUN | {29'h0, md[i]});
         repeat (12) @(posedge clk);
         wr(timer8_pkg::OFF_CTRL, 32'h0);
         rdchk(timer8_pkg::OFF_FLAGS, ex[i], "flags_mode");
      end
   endtask
   // counter written while running: first compare after it must not match
   task automatic t_suppress();
      logic [31:0] cv [2] = '{32'h40, 32'h3e};
      logic [31:0] ex [2] = '{32'h00, 32'h02};
      for (int i = 0; i < 2; i++) begin
         wr(timer8_pkg::OFF_FLAGS, 32'h07);
         wr(timer8_pkg::OFF_CMP_A, 32'h40);
         wr(timer8_pkg::OFF_COUNTER, 32'h00);
         wr(timer8_pkg::OFF_CTRL, RUN);
         wr(timer8_pkg::OFF_COUNTER, cv[i]);
         repeat (2) @(posedge clk);
         wr(timer8_pkg::OFF_CTRL, 32'h0);
         rdchk(timer8_pkg::OFF_FLAGS, ex[i], "flags_after_write");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gset = 1'b0;
      accept = 1'b0;
      slow = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_w1c();
      t_irq();
      t_modes();
      t_suppress();
      final_report();
   end
endmodule
`default_nettype wire
